// file: rtl/set_event_timer.v
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "set_timer_map.vh"

// Notes on behaviour
// [R1] Source select set: count the internal instruction clock.
// [R2] Source select clear: count edges on the external pin.
// [R3] Edge select set counts rising pin edges, clear counts falling.
// [R4] Prescaler divides the source from 1:1 up to 1:256.
// [R5] Counter is 16 bits, counts up and wraps from ffff to 0000.
// [R6] Each wrap sets the overflow flag.
// [R7] Enable clear masks the interrupt; the flag still sets.
// [R8] Vectoring to this interrupt clears the flag in hardware.
// [R9] Synchronisation happens after the prescaler, not before.
// [R10] Prescaler output sampled twice per instruction cycle for edges.
// [R11] External edge reaches the counter 3 to 7 oscillator periods later.
// [R12] Internal source gives one pulse per four-clock instruction cycle.
// [R13] Each detected transition adds exactly one to the counter.
module set_event_timer
(
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire external_count_pin,
  input wire irq_vector_ack,
  output wire irq
);

  localparam [3:0] Q1 = 4'b0001;
  localparam [3:0] Q2 = 4'b0010;
  localparam [3:0] Q3 = 4'b0100;
  localparam [3:0] Q4 = 4'b1000;

  reg [3:0] phase_reg;
  reg [3:0] phase_next;

  reg [3:0] ps_sel_reg;
  reg clock_source_select_reg;
  reg edge_polarity_select_reg;
  reg [15:0] event_counter_reg;
  reg [15:0] event_counter_next;
  reg overflow_flag_reg;
  reg overflow_flag_next;
  reg overflow_irq_enable_reg;

  reg prescaler_output_meta_reg;
  reg prescaler_output_sync_reg;
  reg prescaler_output_smp_reg;
  reg tick_reg;
  reg [2:0] settle_reg;

  wire setup_phase;
  wire wr_en;
  wire hit_ctrl;
  wire hit_count;
  wire hit_status;
  wire hit_enable;
  wire hit_clear;
  wire hit_any;
  wire wr_ctrl;
  wire wr_count;
  wire wr_enable;
  wire wr_clear;
  wire cycle_level;
  wire pin_level;
  wire src_level;
  wire prescaler_output;
  wire sample_now;
  wire settled;
  wire prescale_restart;
  wire wrap;
  wire ovf_set;
  wire ovf_clr;
  wire [31:0] ctrl_view;
  reg [31:0] rd_mux;

  // Instruction cycle phases
  always @*
  begin
    case (phase_reg)
      Q1:
        phase_next = Q2;
      Q2:
        phase_next = Q3;
      Q3:
        phase_next = Q4;
      Q4:
        phase_next = Q1;
      default:
        phase_next = Q1;
    endcase
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      phase_reg <= Q1;
    else
      phase_reg <= phase_next;
  end

  // Bus decode
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit_ctrl = (paddr == `SET_OFF_CTRL);
  assign hit_count = (paddr == `SET_OFF_COUNT);
  assign hit_status = (paddr == `SET_OFF_STATUS);
  assign hit_enable = (paddr == `SET_OFF_ENABLE);
  assign hit_clear = (paddr == `SET_OFF_CLEAR);
  assign hit_any = hit_ctrl | hit_count | hit_status | hit_enable | hit_clear;
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_count = wr_en & hit_count;
  assign wr_enable = wr_en & hit_enable;
  assign wr_clear = wr_en & hit_clear;

  // Zero wait states; read data is staged in setup
  assign pready = 1'b1;

  // Control register
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ps_sel_reg <= `SET_PS_RST;
      clock_source_select_reg <= `SET_CSEL_RST;
      edge_polarity_select_reg <= `SET_EDGE_RST;
    end
    else if (wr_ctrl)
    begin
      ps_sel_reg <= pwdata[`SET_CTRL_PS_MSB:`SET_CTRL_PS_LSB];
      clock_source_select_reg <= pwdata[`SET_CTRL_CSEL_BIT];
      edge_polarity_select_reg <= pwdata[`SET_CTRL_EDGE_BIT];
    end
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      overflow_irq_enable_reg <= `SET_IRQ_EN_RST;
    else if (wr_enable)
      overflow_irq_enable_reg <= pwdata[`SET_IRQ_OVF_BIT];
  end

  // [R12] Square wave at the instruction rate
  assign cycle_level = phase_reg[0] | phase_reg[1];

  // [R3] Falling edges become rising by inversion
  assign pin_level = edge_polarity_select_reg ? external_count_pin : ~external_count_pin;

  // [R1] [R2] Source choice
  // Control writes re-prime the edge path below
  assign src_level = clock_source_select_reg ? cycle_level : pin_level;

  // Settle window after reset or a control write
  // Stale levels would look like an edge; a pin edge inside it is lost
  assign settled = (settle_reg == `SET_SETTLE_CYC);

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      settle_reg <= 3'h0;
    else if (wr_ctrl)
      settle_reg <= 3'h0;
    else if (!settled)
      settle_reg <= settle_reg + 3'h1;
  end

  assign prescale_restart = wr_count | ~settled;

  // [R4] Prescaler, restarted on counter writes and while settling
  set_prescaler u_prescaler
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .src_level(src_level),
    .ratio_sel(ps_sel_reg),
    .restart(prescale_restart),
    .prescaler_output(prescaler_output)
  );

  // [R9] Synchroniser after the prescaler
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescaler_output_meta_reg <= 1'b0;
      prescaler_output_sync_reg <= 1'b0;
    end
    else
    begin
      prescaler_output_meta_reg <= prescaler_output;
      prescaler_output_sync_reg <= prescaler_output_meta_reg;
    end
  end

  // [R10] Two samples per cycle, at Q2 and Q4
  // Pulses shorter than two clocks can be missed
  assign sample_now = phase_reg[1] | phase_reg[3];

  // [R11] Pipeline depth sets the 3..7 period delay
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescaler_output_smp_reg <= 1'b0;
      tick_reg <= 1'b0;
    end
    else
    begin
      if (sample_now | ~settled)
        prescaler_output_smp_reg <= prescaler_output_sync_reg;
      tick_reg <= settled & sample_now & prescaler_output_sync_reg & ~prescaler_output_smp_reg;
    end
  end

  // [R5] Wrap at all ones
  assign wrap = tick_reg & ~wr_count & (event_counter_reg == `SET_COUNT_MAX);

  // [R13] One step per detected edge; writes win
  always @*
  begin
    event_counter_next = event_counter_reg;
    if (wr_count)
      event_counter_next = pwdata[15:0];
    else if (tick_reg)
      event_counter_next = event_counter_reg + 16'h0001;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      event_counter_reg <= `SET_COUNT_RST;
    else
      event_counter_reg <= event_counter_next;
  end

  // [R6] Overflow sets the flag
  assign ovf_set = wrap;

  // [R8] Vector entry or software clear
  assign ovf_clr = irq_vector_ack | (wr_clear & pwdata[`SET_IRQ_OVF_BIT]);

  // Set beats clear so no wrap is lost
  always @*
  begin
    overflow_flag_next = ovf_set | (overflow_flag_reg & ~ovf_clr);
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      overflow_flag_reg <= 1'b0;
    else
      overflow_flag_reg <= overflow_flag_next;
  end

  // [R7] Masked interrupt
  assign irq = overflow_flag_reg & overflow_irq_enable_reg;

  assign ctrl_view = {25'h0000000, edge_polarity_select_reg,
                      clock_source_select_reg, 1'b0, ps_sel_reg};

  always @*
  begin
    rd_mux = 32'h00000000;
    if (hit_ctrl)
      rd_mux = ctrl_view;
    else if (hit_count)
      rd_mux = {16'h0000, event_counter_reg};
    else if (hit_status)
      rd_mux = {31'h00000000, overflow_flag_reg};
    else if (hit_enable)
      rd_mux = {31'h00000000, overflow_irq_enable_reg};
  end

  // Read data and error staged in the setup cycle
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~hit_any;
    end
  end

endmodule

// file: rtl/set_timer_map.vh
`ifndef SET_TIMER_MAP_VH
`define SET_TIMER_MAP_VH

// Register byte offsets
`define SET_OFF_CTRL 8'h00
`define SET_OFF_COUNT 8'h04
`define SET_OFF_STATUS 8'h08
`define SET_OFF_ENABLE 8'h0c
`define SET_OFF_CLEAR 8'h10

// Control register fields
`define SET_CTRL_PS_LSB 0
`define SET_CTRL_PS_MSB 3
`define SET_CTRL_CSEL_BIT 5
`define SET_CTRL_EDGE_BIT 6

// Interrupt register fields
`define SET_IRQ_OVF_BIT 0

// Reset values
`define SET_PS_RST 4'h0
`define SET_CSEL_RST 1'b0
`define SET_EDGE_RST 1'b0
`define SET_COUNT_RST 16'h0000
`define SET_IRQ_EN_RST 1'b0

// Prescaler codes 0..8 give 1:1 .. 1:256
`define SET_PS_MAX 4'h8
`define SET_COUNT_MAX 16'hffff

// Edge-to-increment delay in oscillator periods
`define SET_EXT_DLY_MIN_TOSC 3
`define SET_EXT_DLY_MAX_TOSC 7
// One oscillator period is one mclk period
`define SET_TOSC_PER_MCLK 1
// Clocks the edge path is held after reset or a control write
`define SET_SETTLE_CYC 3'h5
`define SET_EXT_DLY_MIN_CYC (`SET_EXT_DLY_MIN_TOSC / `SET_TOSC_PER_MCLK)
`define SET_EXT_DLY_MAX_CYC (`SET_EXT_DLY_MAX_TOSC / `SET_TOSC_PER_MCLK)

`endif

// file: rtl/set_prescaler.v
`timescale 1ns/100ps
`include "set_timer_map.vh"

module set_prescaler
(
  input wire mclk,
  input wire rst_b,
  input wire src_level,
  input wire [3:0] ratio_sel,
  input wire restart,
  output reg prescaler_output
);

  reg src_prev_reg;
  reg [7:0] div_reg;
  reg [7:0] div_next;
  wire src_rise;
  wire [8:0] taps;
  wire [3:0] sel_clamped;

  assign src_rise = src_level & ~src_prev_reg;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      src_prev_reg <= 1'b0;
    else
      src_prev_reg <= src_level;
  end

  always @*
  begin
    div_next = div_reg;
    if (restart)
      div_next = 8'h00;
    else if (src_rise)
      div_next = div_reg + 8'h01;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      div_reg <= 8'h00;
    else
      div_reg <= div_next;
  end

  // [R4] Divider taps
  assign taps[0] = src_level;
  genvar i;
  generate
    for (i = 1; i < 9; i = i + 1)
    begin : g_tap
      assign taps[i] = div_reg[i-1];
    end
  endgenerate

  // Codes above 8 fall back to the slowest ratio
  assign sel_clamped = (ratio_sel > `SET_PS_MAX) ? `SET_PS_MAX : ratio_sel;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      prescaler_output <= 1'b0;
    else
      prescaler_output <= taps[sel_clamped];
  end

endmodule

// file: testbench/set_event_timer_checker.sv
`timescale 1ns/100ps
`include "set_timer_map.vh"
module set_event_timer_checker
(
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire external_count_pin,
  input wire irq_vector_ack,
  input wire irq
);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  AST_ACK_CLR: assert property (irq_vector_ack |=> !irq)
    else $error("irq after ack");
  AST_EN_OFF: assert property (wr && paddr == `SET_OFF_ENABLE && !pwdata[0] |=> !irq)
    else $error("irq not masked");
  AST_W1C: assert property (wr && paddr == `SET_OFF_CLEAR && pwdata[0] |-> ##1 !irq)
    else $error("flag not cleared");
  AST_STICKY: assert property (irq && !irq_vector_ack && !wr |=> $stable(irq))
    else $error("flag lost");
  AST_CNT16: assert property (rd && paddr == `SET_OFF_COUNT |-> ~|prdata[31:16])
    else $error("count too wide");
  AST_STAT: assert property (rd && paddr == `SET_OFF_STATUS && $past(irq) |-> prdata[0])
    else $error("status low");
  AST_EN_RD: assert property (rd && paddr == `SET_OFF_ENABLE && $past(irq) |-> prdata[0])
    else $error("enable low");
  AST_CTRL: assert property (rd && paddr == `SET_OFF_CTRL |-> ~|{prdata[31:7], prdata[4]})
    else $error("ctrl spare bits");
  AST_RDY: assert property (psel && penable |-> pready)
    else $error("access not ready");
endmodule

bind set_event_timer set_event_timer_checker u_chk
(
  .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .external_count_pin, .irq_vector_ack, .irq
);

// file: testbench/set_pin_src.sv
`timescale 1ns/100ps
module set_pin_src
(
  input wire mclk,
  input wire go,
  input wire [7:0] n,
  input wire [3:0] h,
  output logic pin,
  output logic busy
);
  // Level held between bursts; h of 4 or more keeps edges a full cycle apart
  initial
  begin
    pin = 0;
    busy = 0;
    forever
    begin
      @(posedge mclk);
      if (go)
      begin
        busy <= 1;
        repeat (n)
        begin
          repeat (h) @(posedge mclk);
          pin <= ~pin;
        end
        busy <= 0;
      end
    end
  end
endmodule

// file: testbench/set_event_timer_tb.sv
`timescale 1ns/100ps
`include "set_timer_map.vh"
module set_event_timer_tb;
  logic mclk, rst_b, psel, penable, pwrite, ack, go, se;
  logic [7:0] paddr, n;
  logic [3:0] h;
  logic [31:0] pwdata, rd, r1;
  logic [15:0] ld;
  wire [31:0] prdata;
  wire pready, pslverr, irq, pin, busy;
  int err_total, n_tests, p, e, s, m, i;
  set_event_timer dut
  (
    .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_count_pin(pin), .irq_vector_ack(ack), .irq
  );
  set_pin_src src
  (
    .mclk, .go, .n, .h, .pin, .busy
  );
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    n_tests++;
    if (sv !== ev)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic hang(input int j, input int lim);
    if (j >= lim)
    begin
      err_total++;
      report_and_stop;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    for (j = 0; j < 20 && pready !== 1; j++) @(posedge mclk);
    hang(j, 20);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc;
    apb(0, `SET_OFF_COUNT, 0);
  endtask
  function automatic int edges(input int s0, input int m0, input int e0);
    return (s0 ^ e0) ? (m0 + 1) / 2 : m0 / 2;
  endfunction
  initial
  begin
    {rst_b, psel, penable, pwrite, ack, go} = 0;
    paddr = 0;
    pwdata = 0;
    n = 0;
    h = 4;
    r1 = $urandom(6561);
    cyc(2);
    rst_b <= 1;
    for (int a = 0; a < 6; a++)
    begin
      apb(0, 8'(a * 4), 0);
      chk(rd, 0);
      chk(se, a == 5);
    end
    // Pin never moved, so no count may appear after reset
    rdc;
    chk(rd, 0);
    // Whole prescaler periods make the tick count exact
    for (p = 0; p < 9; p++)
    begin
      apb(1, `SET_OFF_CTRL, 32'h20 | p);
      cyc(12);
      rdc;
      r1 = rd;
      cyc(1021);
      rdc;
      chk((rd - r1) & 32'hffff, 32'd256 >> p);
    end
    apb(1, `SET_OFF_CTRL, 32'h20);
    apb(1, `SET_OFF_ENABLE, 1);
    apb(1, `SET_OFF_COUNT, 32'hffff);
    cyc(10);
    chk(irq, 1);
    rdc;
    chk(rd < 6, 1);
    ack <= 1;
    cyc(1);
    ack <= 0;
    cyc(1);
    chk(irq, 0);
    apb(1, `SET_OFF_ENABLE, 0);
    apb(1, `SET_OFF_COUNT, 32'hffff);
    cyc(10);
    chk(irq, 0);
    apb(0, `SET_OFF_STATUS, 0);
    chk(rd, 1);
    apb(1, `SET_OFF_ENABLE, 1);
    cyc(1);
    chk(irq, 1);
    apb(0, `SET_OFF_ENABLE, 0);
    chk(rd, 1);
    apb(1, `SET_OFF_CLEAR, 1);
    cyc(1);
    chk(irq, 0);
    for (int k = 0; k < 10; k++)
    begin
      p = $urandom % 3;
      e = $urandom % 2;
      apb(1, `SET_OFF_CTRL, (e << 6) | p);
      cyc(12);
      ld = 16'($urandom);
      apb(1, `SET_OFF_COUNT, ld);
      s = pin;
      m = ((($urandom % 3) + 1) << (p + 1)) + (p == 0 ? $urandom % 2 : 0);
      n <= 8'(m);
      h <= 4'(5 + $urandom % 4);
      go <= 1;
      cyc(1);
      go <= 0;
      cyc(1);
      for (i = 0; i < 500 && busy !== 0; i++) cyc(1);
      hang(i, 500);
      if (p == 0)
      begin
        rdc;
        chk(rd, 16'(ld + edges(s, m - 1, e)));
      end
      cyc(10);
      rdc;
      chk(rd, 16'(ld + (edges(s, m, e) >> p)));
    end
    report_and_stop;
  end
endmodule
